/* File: rtl/ocm_pkg.sv */
// What this block does
// - first window access returns byte at pointer
// - later window accesses advance ROM address by one
// - index stops incrementing after first window access
// - transaction end releases window streaming and lock
// - ROM window eight bits, read-only, resets zero
// - key write must directly precede program trigger
// - key resets zero; only 0xea arms programming
// - foreign bus traffic invalidates running program cycle
// - four-bit commit page, values 0-15, resets zero
// - two GPIO pins pick power-up page
// - slow power-up bits at 6 and 2
// - slow mode adds about 60 ms power-on delay only when both loop bandwidth selects are high
// - twelve-bit start pointer from nibble plus byte
package ocm_pkg;
  // register offsets
  localparam logic [7:0] OFS_NV_CTRL = 8'h88;
  localparam logic [7:0] OFS_PTR_HI = 8'h8b;
  localparam logic [7:0] OFS_PTR_LO = 8'h8c;
  localparam logic [7:0] OFS_ROM_WIN = 8'h8f;
  localparam logic [7:0] OFS_UNLOCK = 8'h90;
  localparam logic [7:0] OFS_PAGE = 8'h91;
  localparam logic [7:0] OFS_POR = 8'had;
  // field positions and values
  localparam int BIT_PROG_TRIG = 0;
  localparam int BIT_LOOP_TWO_SLOW = 6;
  localparam int BIT_LOOP_ONE_SLOW = 2;
  localparam logic [7:0] UNLOCK_KEY = 8'hea;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [11:0] RST_PTR = 12'h000;
  // power-on slow ramp timing
  localparam int POR_SLOW_MS = 60;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_SLOW_CYC = POR_SLOW_MS * 1000000 / CLK_PERIOD_NS;
  // byte-level request from the serial target engine
  typedef struct packed {
    logic start;
    logic stop;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_req;
  } ocm_req_t;
  typedef enum logic [2:0] {
    POR_BOOT = 3'b001,
    POR_SLOW = 3'b010,
    POR_DONE = 3'b100
  } ocm_por_t;
endpackage : ocm_pkg

/* File: rtl/ocm_access.sv */
`timescale 1ns/100ps
module ocm_access import ocm_pkg::*; #(
  parameter int unsigned SLOW_CYCLES = POR_SLOW_CYC
) (
  input wire logic CLK, // core clock
  input wire logic RST, // sync reset, active high
  input wire ocm_req_t HOST_REQ, // byte events from serial target
  output logic [7:0] RD_DATA, // read byte
  output logic RD_VALID, // read byte valid pulse
  output logic [11:0] ROM_ADDR, // ROM address
  input wire logic [7:0] ROM_DATA, // ROM data, async on ROM_ADDR
  input wire logic FOREIGN_TRAFFIC, // bus packet to another target
  input wire logic PROG_DONE, // program cycle finished
  output logic PROG_START, // program cycle start pulse
  output logic PROG_ABORT, // program cycle invalidated pulse
  output logic PROG_BUSY, // program cycle running
  output logic [3:0] PROG_PAGE, // commit page
  input wire logic [1:0] GPIO_PAGE, // power-up page pins
  input wire logic [1:0] NV_POR_SLOW, // stored slow bits {two,one}
  input wire logic LOOP_ONE_BW, // loop one bandwidth select
  input wire logic LOOP_TWO_BW, // loop two bandwidth select
  output logic [3:0] POWERUP_PAGE, // page chosen at power-up
  output logic POR_COMPLETE // power-on sequence done
);
  logic have_idx_q, stream_q, armed_q, boot_q;
  logic [7:0] idx_q, key_q, rom_win_q, rd_hold_q;
  logic [3:0] page_q;
  logic [11:0] ptr_q;
  logic [1:0] slow_q;
  logic rd_pend_q, rd_rom_q;
  logic [31:0] por_cnt_q;
  ocm_por_t por_q;
  logic wr_acc, rd_acc, acc, acc_win, end_xfer;
  logic [7:0] rd_mux;

  // access decode
  assign end_xfer = HOST_REQ.start | HOST_REQ.stop;
  assign wr_acc = HOST_REQ.wr_valid & have_idx_q & ~end_xfer;
  assign rd_acc = HOST_REQ.rd_req & ~end_xfer;
  assign acc = wr_acc | rd_acc;
  assign acc_win = acc && idx_q == OFS_ROM_WIN;

  // register read mux, unmapped reads zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx_q)
      OFS_NV_CTRL: rd_mux = {7'h00, PROG_BUSY};
      OFS_PTR_HI: rd_mux = {4'h0, ptr_q[11:8]};
      OFS_PTR_LO: rd_mux = ptr_q[7:0];
      OFS_ROM_WIN: rd_mux = rom_win_q;
      OFS_UNLOCK: rd_mux = key_q;
      OFS_PAGE: rd_mux = {4'h0, page_q};
      OFS_POR: rd_mux = {1'b0, slow_q[1], 3'h0, slow_q[0], 2'h0};
      default: rd_mux = 8'h00;
    endcase
  end

  // register index and window lock
  always_ff @(posedge CLK) begin
    if (RST) begin
      idx_q <= RST_BYTE;
      have_idx_q <= 1'b0;
      stream_q <= 1'b0;
    end else if (end_xfer) begin
      have_idx_q <= 1'b0;
      stream_q <= 1'b0;
    end else if (HOST_REQ.wr_valid && !have_idx_q) begin
      idx_q <= HOST_REQ.wr_data;
      have_idx_q <= 1'b1;
    end else if (acc_win) begin
      stream_q <= 1'b1;
    end else if (acc) begin
      idx_q <= idx_q + 8'h01;
    end
  end

  // ROM address stepping
  always_ff @(posedge CLK) begin
    if (RST) begin
      ROM_ADDR <= RST_PTR;
    end else if (acc_win) begin
      ROM_ADDR <= stream_q ? ROM_ADDR + 12'h001 : ptr_q;
    end
  end

  // read return, two cycles after request
  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_pend_q <= 1'b0;
      rd_rom_q <= 1'b0;
      rd_hold_q <= RST_BYTE;
      RD_DATA <= RST_BYTE;
      RD_VALID <= 1'b0;
      rom_win_q <= RST_BYTE;
    end else begin
      rd_pend_q <= rd_acc;
      rd_rom_q <= rd_acc & acc_win;
      rd_hold_q <= rd_mux;
      RD_VALID <= rd_pend_q;
      if (rd_pend_q) begin
        RD_DATA <= rd_rom_q ? ROM_DATA : rd_hold_q;
      end
      if (rd_pend_q && rd_rom_q) begin
        rom_win_q <= ROM_DATA;
      end
    end
  end

  // writable registers; window writes store nothing but still step ROM_ADDR
  always_ff @(posedge CLK) begin
    if (RST) begin
      ptr_q <= RST_PTR;
      key_q <= RST_BYTE;
      page_q <= RST_PAGE;
    end else if (wr_acc) begin
      unique case (idx_q)
        OFS_PTR_HI: ptr_q[11:8] <= HOST_REQ.wr_data[3:0];
        OFS_PTR_LO: ptr_q[7:0] <= HOST_REQ.wr_data;
        OFS_UNLOCK: key_q <= HOST_REQ.wr_data;
        OFS_PAGE: page_q <= HOST_REQ.wr_data[3:0];
        default: ;
      endcase
    end
  end

  // unlock arming: only the access directly before the trigger
  always_ff @(posedge CLK) begin
    if (RST) begin
      armed_q <= 1'b0;
    end else if (acc) begin
      armed_q <= wr_acc && idx_q == OFS_UNLOCK &&
                 HOST_REQ.wr_data == UNLOCK_KEY;
    end
  end

  // program cycle control
  always_ff @(posedge CLK) begin
    if (RST) begin
      PROG_START <= 1'b0;
      PROG_ABORT <= 1'b0;
      PROG_BUSY <= 1'b0;
      PROG_PAGE <= RST_PAGE;
    end else begin
      PROG_START <= 1'b0;
      PROG_ABORT <= 1'b0;
      PROG_PAGE <= page_q;
      if (PROG_BUSY && FOREIGN_TRAFFIC) begin
        PROG_ABORT <= 1'b1;
        PROG_BUSY <= 1'b0;
      end else if (PROG_BUSY && PROG_DONE) begin
        PROG_BUSY <= 1'b0;
      end else if (!PROG_BUSY && wr_acc && idx_q == OFS_NV_CTRL &&
                   HOST_REQ.wr_data[BIT_PROG_TRIG] && armed_q) begin
        PROG_START <= 1'b1;
        PROG_BUSY <= 1'b1;
      end
    end
  end

  // slow bits: loaded from storage after reset, then writable
  always_ff @(posedge CLK) begin
    if (RST) begin
      boot_q <= 1'b1;
      slow_q <= 2'b00;
      POWERUP_PAGE <= RST_PAGE;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      slow_q <= NV_POR_SLOW;
      POWERUP_PAGE <= {2'b00, GPIO_PAGE};
    end else if (wr_acc && idx_q == OFS_POR) begin
      slow_q <= {HOST_REQ.wr_data[BIT_LOOP_TWO_SLOW],
                 HOST_REQ.wr_data[BIT_LOOP_ONE_SLOW]};
    end
  end

  // power-on sequence with optional slow delay
  always_ff @(posedge CLK) begin
    if (RST) begin
      por_q <= POR_BOOT;
      por_cnt_q <= 32'h0000_0000;
      POR_COMPLETE <= 1'b0;
    end else begin
      unique case (por_q)
        POR_BOOT: begin
          if (!boot_q) begin
            if (|slow_q && LOOP_ONE_BW && LOOP_TWO_BW) begin
              por_q <= POR_SLOW;
            end else begin
              por_q <= POR_DONE;
              POR_COMPLETE <= 1'b1;
            end
          end
        end
        POR_SLOW: begin
          por_cnt_q <= por_cnt_q + 32'h0000_0001;
          if (por_cnt_q >= SLOW_CYCLES - 1) begin
            por_q <= POR_DONE;
            POR_COMPLETE <= 1'b1;
          end
        end
        POR_DONE: POR_COMPLETE <= 1'b1;
        default: por_q <= POR_BOOT;
      endcase
    end
  end

  property p_first_addr;
    @(posedge CLK) disable iff (RST)
    acc_win && !stream_q |=> ROM_ADDR == $past(ptr_q);
  endproperty
  a_first_addr: assert property (p_first_addr)
    else $error("window start not at pointer");
  property p_step;
    @(posedge CLK) disable iff (RST)
    acc_win && stream_q |=> ROM_ADDR == $past(ROM_ADDR) + 12'h001;
  endproperty
  a_step: assert property (p_step)
    else $error("window address did not advance");
  property p_lock;
    @(posedge CLK) disable iff (RST)
    stream_q && !end_xfer |=> idx_q == OFS_ROM_WIN;
  endproperty
  a_lock: assert property (p_lock)
    else $error("index moved while locked");
  property p_release;
    @(posedge CLK) disable iff (RST) end_xfer |=> !stream_q && !have_idx_q;
  endproperty
  a_release: assert property (p_release)
    else $error("lock not released at transaction end");
  property p_rom_data;
    @(posedge CLK) disable iff (RST)
    rd_acc && acc_win ##1 1'b1 |=> RD_VALID && RD_DATA == $past(ROM_DATA);
  endproperty
  a_rom_data: assert property (p_rom_data)
    else $error("window read returned wrong byte");
  property p_unlock;
    @(posedge CLK) disable iff (RST) $rose(PROG_START) |-> $past(armed_q);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("program started without key");
  property p_abort;
    @(posedge CLK) disable iff (RST)
    PROG_BUSY && FOREIGN_TRAFFIC |=> PROG_ABORT && !PROG_BUSY;
  endproperty
  a_abort: assert property (p_abort)
    else $error("foreign traffic did not abort");
  property p_page;
    @(posedge CLK) disable iff (RST) PROG_START |-> PROG_PAGE == $past(page_q);
  endproperty
  a_page: assert property (p_page)
    else $error("commit page mismatch");
  property p_fast_por;
    @(posedge CLK) disable iff (RST)
    por_q == POR_BOOT && !boot_q && slow_q == 2'b00 |=> POR_COMPLETE;
  endproperty
  a_fast_por: assert property (p_fast_por)
    else $error("power-on delayed without slow bits");
  property p_slow_por;
    @(posedge CLK) disable iff (RST)
    por_q == POR_SLOW && por_cnt_q < SLOW_CYCLES - 1 |=> !POR_COMPLETE;
  endproperty
  a_slow_por: assert property (p_slow_por)
    else $error("slow power-on ended early");
  c_stream: cover property (@(posedge CLK) acc_win && stream_q);
  c_prog: cover property (@(posedge CLK) PROG_START);
  c_abort: cover property (@(posedge CLK) PROG_ABORT);
  c_slow: cover property (@(posedge CLK) por_q == POR_SLOW);
endmodule : ocm_access

/* File: verif/ocm_far.sv */
`timescale 1ns/100ps
module ocm_far import ocm_pkg::*; #(
  parameter int DONE_DLY = 30
) (
  input wire logic CLK, // core clock
  input wire logic RST, // sync reset
  input wire logic [11:0] ROM_ADDR, // ROM address
  output logic [7:0] ROM_DATA, // ROM byte
  input wire logic PROG_BUSY, // program running
  output logic PROG_DONE // program finished pulse
);
  int cnt_q;
  // ROM content, low address byte XORed with {high address nibble, 0x5}
  assign ROM_DATA = ROM_ADDR[7:0] ^ {ROM_ADDR[11:8], 4'h5};
  // program engine finishes a fixed time after busy rises
  always_ff @(posedge CLK) begin
    if (RST || !PROG_BUSY) begin
      cnt_q <= 0;
      PROG_DONE <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1;
      PROG_DONE <= (cnt_q == DONE_DLY);
    end
  end
endmodule : ocm_far

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench import ocm_pkg::*;;
  logic CLK = 1'b0, RST = 1'b1, FT = 1'b0, BW1 = 1'b0, BW2 = 1'b0, RV, PS;
  logic PA, PB, PD, PC;
  logic [1:0] GP = 2'b00, NS = 2'b00;
  logic [7:0] RD, RDT, v;
  logic [11:0] RA;
  logic [3:0] PP, UP;
  ocm_req_t req = '0;
  int n_fail = 0, cmp_count = 0, n_start = 0, n_abort = 0, n;
  always #5 CLK = ~CLK;
  ocm_access #(.SLOW_CYCLES(20)) dut (.CLK(CLK), .RST(RST), .HOST_REQ(req),
    .RD_DATA(RD), .RD_VALID(RV), .ROM_ADDR(RA), .ROM_DATA(RDT),
    .FOREIGN_TRAFFIC(FT), .PROG_DONE(PD), .PROG_START(PS), .PROG_ABORT(PA),
    .PROG_BUSY(PB), .PROG_PAGE(PP), .GPIO_PAGE(GP), .NV_POR_SLOW(NS),
    .LOOP_ONE_BW(BW1), .LOOP_TWO_BW(BW2), .POWERUP_PAGE(UP),
    .POR_COMPLETE(PC));
  ocm_far far (.CLK(CLK), .RST(RST), .ROM_ADDR(RA), .ROM_DATA(RDT),
    .PROG_BUSY(PB), .PROG_DONE(PD));
  // count program pulses
  always @(posedge CLK) begin
    if (PS === 1'b1) n_start++;
    if (PA === 1'b1) n_abort++;
  end
  function automatic logic [7:0] rom(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction : rom
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one byte event per cycle
  task automatic put(input logic s, p, w, input logic [7:0] d, input logic r);
    @(posedge CLK);
    #1;
    req = '{start: s, stop: p, wr_valid: w, wr_data: d, rd_req: r};
  endtask : put
  task automatic go(input logic [7:0] idx);
    put(1, 0, 0, 8'h00, 0);
    put(0, 0, 1, idx, 0);
  endtask : go
  task automatic halt();
    put(0, 1, 0, 8'h00, 0);
    put(0, 0, 0, 8'h00, 0);
  endtask : halt
  task automatic rdb(output logic [7:0] b);
    int i;
    put(0, 0, 0, 8'h00, 1);
    put(0, 0, 0, 8'h00, 0);
    for (i = 0; i < 6 && RV !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (i == 6) begin
      n_fail++;
      end_of_test();
    end
    b = RD;
  endtask : rdb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    go(idx);
    put(0, 0, 1, d, 0);
    halt();
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    go(idx);
    rdb(v);
    chk("reg", e, v);
    halt();
  endtask : rd
  task automatic boot(input logic [1:0] g, s, input logic bw, input int cyc);
    RST = 1'b1;
    GP = g;
    NS = s;
    BW1 = 1'b1;
    BW2 = bw;
    repeat (12) @(posedge CLK);
    #1;
    RST = 1'b0;
    for (n = 0; n < 60 && PC !== 1'b1; n++) begin
      @(posedge CLK);
      #1;
    end
    if (n == 60) begin
      n_fail++;
      end_of_test();
    end
    chk("por", 8'(cyc), 8'(n));
    chk("page", {6'h00, g}, UP);
  endtask : boot
  initial begin
    boot(2'b10, 2'b01, 1'b1, 22);
    rd(OFS_POR, 8'h04);
    wr(OFS_POR, 8'h40);
    rd(OFS_POR, 8'h40);
    // pointer through auto-incremented index
    go(OFS_PTR_HI);
    put(0, 0, 1, 8'h01, 0);
    put(0, 0, 1, 8'hfe, 0);
    halt();
    go(OFS_ROM_WIN);
    for (int k = 0; k < 3; k++) begin
      rdb(v);
      chk("win", rom(12'(12'h1fe + k)), v);
    end
    halt();
    go(OFS_ROM_WIN);
    rdb(v);
    chk("win", rom(12'h1fe), v);
    put(0, 0, 1, 8'h33, 0);
    rdb(v);
    chk("win", rom(12'h200), v);
    halt();
    go(OFS_PTR_HI);
    rdb(v);
    chk("ptr_hi", 8'h01, v);
    rdb(v);
    chk("ptr_lo", 8'hfe, v);
    halt();
    rd(OFS_UNLOCK, 8'h00);
    rd(OFS_PAGE, 8'h00);
    // armed trigger, runs to completion
    wr(OFS_UNLOCK, UNLOCK_KEY);
    wr(OFS_NV_CTRL, 8'h01);
    repeat (3) @(posedge CLK);
    #1;
    chk("busy", 8'h01, {7'h0, PB});
    rd(OFS_NV_CTRL, 8'h01);
    repeat (40) @(posedge CLK);
    #1;
    chk("busy", 8'h00, {7'h0, PB});
    // other access between key and trigger
    wr(OFS_UNLOCK, UNLOCK_KEY);
    wr(OFS_PAGE, 8'h05);
    wr(OFS_NV_CTRL, 8'h01);
    rd(OFS_PAGE, 8'h05);
    chk("prog_page", 8'h05, {4'h0, PP});
    wr(OFS_UNLOCK, 8'heb);
    wr(OFS_NV_CTRL, 8'h01);
    chk("starts", 8'h01, 8'(n_start));
    // foreign traffic invalidates the cycle
    wr(OFS_UNLOCK, UNLOCK_KEY);
    wr(OFS_NV_CTRL, 8'h01);
    FT = 1'b1;
    @(posedge CLK);
    #1 FT = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk("abort", 8'h01, 8'(n_abort));
    chk("busy", 8'h00, {7'h0, PB});
    chk("starts", 8'h02, 8'(n_start));
    boot(2'b11, 2'b00, 1'b1, 2);
    rd(OFS_UNLOCK, 8'h00);
    // slow bit stored but one bandwidth bit low: no slow delay
    boot(2'b01, 2'b10, 1'b0, 2);
    rd(OFS_POR, 8'h40);
    end_of_test();
  end
endmodule : testbench
